// ==== design/hps_pkg.sv ====
// Constants for the dual-slot hot-plug fault and status logic.
// Assumes one system clock; pin inputs are synchronised before use.
// Behaviour
// - Slot trip pulls its fault pin low
// - Main enable low releases main fault
// - Aux enable low releases aux fault
// - Both faults need both enables low
// - Override low forces outputs, skips protections
// - Aux undervoltage lockout still enforced
// - Override releases power-good and fault pins
// - Registers keep fault and main-on state during override; power-good and aux output bits show the forced pins
// - Control bits disable either override input
// - Common status shows general inputs live
// - Address pins captured once after power-up
// - Interrupt low on fault unless masked
// - Echo write of fault bits clears interrupt
// - Main enable rising edge turns main on
// - Aux enable is level sensitive
// - Power-good only when on and delivering
package hps_pkg;

  localparam int unsigned HPS_DW     = 8;
  localparam int unsigned HPS_AW     = 3;
  localparam int unsigned HPS_SLOTS  = 2;
  localparam int unsigned HPS_SLOT_W = 11;
  localparam int unsigned HPS_SYNC_W = HPS_SLOTS * HPS_SLOT_W + 5;

  // Register indices
  localparam logic [2:0] HPS_REG_CONTROL = 3'h0;
  localparam logic [2:0] HPS_REG_COMMON  = 3'h1;
  localparam logic [2:0] HPS_REG_SLOT_A  = 3'h2;
  localparam logic [2:0] HPS_REG_SLOT_B  = 3'h3;
  localparam logic [2:0] HPS_REG_IRQSTAT = 3'h4;
  localparam logic [2:0] HPS_REG_IRQMASK = 3'h5;
  localparam logic [2:0] HPS_REG_ADDR    = 3'h6;

  // Control register fields
  localparam int unsigned HPS_CTRL_OVD_A = 2;
  localparam int unsigned HPS_CTRL_OVD_B = 3;

  // Common status fields
  localparam int unsigned HPS_CS_FLT_A = 0;
  localparam int unsigned HPS_CS_FLT_B = 1;
  localparam int unsigned HPS_CS_MASK  = 3;
  localparam int unsigned HPS_CS_GPA   = 4;
  localparam int unsigned HPS_CS_GPB   = 5;

  // Slot status fields
  localparam int unsigned HPS_SS_MAIN_FLT = 0;
  localparam int unsigned HPS_SS_AUX_FLT  = 1;

  // Reset values
  localparam logic [7:0] HPS_CTRL_RST    = 8'h00;
  localparam logic       HPS_MASKBIT_RST = 1'b0;
  localparam logic [3:0] HPS_IRQEN_RST   = 4'hF;
  localparam logic [2:0] HPS_ADDR_RST    = 3'h7;

  // Synchroniser idle levels: both override pins released
  localparam logic [HPS_SYNC_W-1:0] HPS_SYNC_RST = 27'h0002004;

  // Cycles after reset before the address pins are sampled
  localparam logic [1:0] HPS_ADDR_CAP_DLY = 2'h2;

endpackage : hps_pkg

// ==== design/hps_slot.sv ====
// One slot: enable, fault latch, override and power-good logic.
// Assumes all inputs are already synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module hps_slot
  import hps_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic mainEn,
  input  wire logic aux_enable,
  input  wire logic overrideN,
  input  wire logic overrideDis,
  input  wire logic mainOc,
  input  wire logic mainUv,
  input  wire logic mainOt,
  input  wire logic auxOc,
  input  wire logic auxOt,
  input  wire logic auxUvlo,
  input  wire logic mainPwrOk,
  input  wire logic auxPwrOk,
  output var  logic mainOut_r,
  output var  logic auxOut_r,
  output var  logic faultN_r,
  output var  logic powerGoodN_r,
  output var  logic mainOn_r,
  output var  logic auxOn_r,
  output var  logic mainFault_r,
  output var  logic auxFault_r,
  output var  logic forceOn_r,
  output var  logic mainFaultEv_r,
  output var  logic auxFaultEv_r
);

  logic mainEnD_r;
  logic forceAct;
  logic mainTrip;
  logic auxTrip;

  assign forceAct = ~overrideN & ~overrideDis;
  assign mainTrip = mainOn_r & (mainOc | mainUv | mainOt) & ~forceAct;
  assign auxTrip  = auxOn_r & (auxOc | auxOt) & ~forceAct;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mainEnD_r <= 1'b0;
    end else if (ce) begin
      mainEnD_r <= mainEn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mainOn_r <= 1'b0;
    end else if (ce) begin
      if (!mainEn || mainTrip) begin
        mainOn_r <= 1'b0;
      end else if (!mainEnD_r && !mainFault_r && !mainUv) begin
        mainOn_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mainFault_r <= 1'b0;
    end else if (ce) begin
      if (mainTrip) begin
        mainFault_r <= 1'b1;
      end else if (!mainEn) begin
        mainFault_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      auxFault_r <= 1'b0;
    end else if (ce) begin
      if (auxTrip) begin
        auxFault_r <= 1'b1;
      end else if (!aux_enable) begin
        auxFault_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      auxOn_r <= 1'b0;
    end else if (ce) begin
      auxOn_r <= aux_enable & ~auxUvlo & ~auxFault_r & ~auxTrip;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mainOut_r     <= 1'b0;
      auxOut_r      <= 1'b0;
      faultN_r      <= 1'b1;
      powerGoodN_r  <= 1'b1;
      forceOn_r     <= 1'b0;
      mainFaultEv_r <= 1'b0;
      auxFaultEv_r  <= 1'b0;
    end else if (ce) begin
      mainOut_r <= forceAct | mainOn_r;
      auxOut_r  <= (forceAct | auxOn_r) & ~auxUvlo;
      faultN_r  <= forceAct | ~(mainFault_r | auxFault_r);
      powerGoodN_r <= forceAct |
        ~(mainOn_r & auxOn_r & mainPwrOk & auxPwrOk);
      forceOn_r     <= forceAct;
      mainFaultEv_r <= mainTrip & ~mainFault_r;
      auxFaultEv_r  <= auxTrip & ~auxFault_r;
    end
  end

endmodule // hps_slot
`default_nettype wire

// ==== design/hps_sync.sv ====
// Two-stage synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module hps_sync
  import hps_pkg::*;
#(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] stage1_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_r <= RST_VAL;
      q        <= RST_VAL;
    end else if (ce) begin
      stage1_r <= d;
      q        <= stage1_r;
    end
  end

endmodule // hps_sync
`default_nettype wire

// ==== design/hps_top.sv ====
// Top of the dual-slot fault, override and interrupt logic.
// Assumes pins are asynchronous and a plain register port on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module hps_top
  import hps_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic              slot_a_main_enable,
  input  wire logic              slot_a_aux_enable,
  input  wire logic              slot_a_override_n,
  input  wire logic              slot_a_main_oc,
  input  wire logic              slot_a_main_uv,
  input  wire logic              slot_a_main_ot,
  input  wire logic              slot_a_aux_oc,
  input  wire logic              slot_a_aux_ot,
  input  wire logic              slot_a_aux_undervoltage_lockout,
  input  wire logic              slot_a_main_pwr_ok,
  input  wire logic              slot_a_aux_pwr_ok,
  input  wire logic              slot_b_main_enable,
  input  wire logic              slot_b_aux_enable,
  input  wire logic              slot_b_override_n,
  input  wire logic              slot_b_main_oc,
  input  wire logic              slot_b_main_uv,
  input  wire logic              slot_b_main_ot,
  input  wire logic              slot_b_aux_oc,
  input  wire logic              slot_b_aux_ot,
  input  wire logic              slot_b_aux_undervoltage_lockout,
  input  wire logic              slot_b_main_pwr_ok,
  input  wire logic              slot_b_aux_pwr_ok,
  input  wire logic              gp_input_a,
  input  wire logic              gp_input_b,
  input  wire logic              addr_sel_2,
  input  wire logic              addr_sel_1,
  input  wire logic              addr_sel_0,
  input  wire logic [HPS_AW-1:0] regAddr,
  input  wire logic [HPS_DW-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [HPS_DW-1:0] regRdata,
  output var  logic              slot_a_fault_n,
  output var  logic              slot_b_fault_n,
  output var  logic              slot_a_power_good_n,
  output var  logic              slot_b_power_good_n,
  output var  logic              slot_a_main_output,
  output var  logic              slot_b_main_output,
  output var  logic              slot_a_aux_output,
  output var  logic              slot_b_aux_output,
  output var  logic              irq_n,
  output var  logic [2:0]        busBaseAddr
);

  function automatic logic regHit(input logic [HPS_AW-1:0] a,
                                  input logic [HPS_AW-1:0] off);
    regHit = (a == off);
  endfunction

  logic [HPS_SYNC_W-1:0] pinRaw;
  logic [HPS_SYNC_W-1:0] pinSync;
  logic [HPS_SLOT_W-1:0] slotPin [HPS_SLOTS];

  logic [HPS_SLOTS-1:0]  mainOut;
  logic [HPS_SLOTS-1:0]  auxOut;
  logic [HPS_SLOTS-1:0]  faultN;
  logic [HPS_SLOTS-1:0]  pgN;
  logic [HPS_SLOTS-1:0]  mainOn;
  logic [HPS_SLOTS-1:0]  auxOn;
  logic [HPS_SLOTS-1:0]  mainFault;
  logic [HPS_SLOTS-1:0]  auxFault;
  logic [HPS_SLOTS-1:0]  forceOn;
  logic [HPS_SLOTS-1:0]  mainEv;
  logic [HPS_SLOTS-1:0]  auxEv;
  logic [HPS_SLOTS-1:0]  ovDis;

  logic [HPS_DW-1:0]     control_reg_r;
  logic                  irq_mask_bit_r;
  logic [3:0]            irqStat_r;
  logic [3:0]            irqStat_nxt;
  logic [3:0]            irqEn_r;
  logic [3:0]            irqSet;
  logic [3:0]            irqClr;
  logic [2:0]            baseAddr_r;
  logic [1:0]            capCnt_r;
  logic                  captured_r;
  logic [HPS_DW-1:0]     rdMux;
  logic [HPS_DW-1:0]     slotStat [HPS_SLOTS];
  logic                  gpA;
  logic                  gpB;
  logic [2:0]            addrPins;

  assign pinRaw = {
    gp_input_b, gp_input_a, addr_sel_2, addr_sel_1, addr_sel_0,
    slot_b_aux_pwr_ok, slot_b_main_pwr_ok, slot_b_aux_undervoltage_lockout,
    slot_b_aux_ot, slot_b_aux_oc, slot_b_main_ot, slot_b_main_uv,
    slot_b_main_oc, slot_b_override_n, slot_b_aux_enable,
    slot_b_main_enable,
    slot_a_aux_pwr_ok, slot_a_main_pwr_ok, slot_a_aux_undervoltage_lockout,
    slot_a_aux_ot, slot_a_aux_oc, slot_a_main_ot, slot_a_main_uv,
    slot_a_main_oc, slot_a_override_n, slot_a_aux_enable,
    slot_a_main_enable
  };

  // Reset to idle pin levels so no false override follows reset
  hps_sync #(
    .W       (HPS_SYNC_W),
    .RST_VAL (HPS_SYNC_RST)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (pinRaw),
    .q       (pinSync)
  );

  assign addrPins = pinSync[HPS_SLOTS*HPS_SLOT_W +: 3];
  assign gpA      = pinSync[HPS_SLOTS*HPS_SLOT_W + 3];
  assign gpB      = pinSync[HPS_SLOTS*HPS_SLOT_W + 4];
  assign ovDis    = {control_reg_r[HPS_CTRL_OVD_B],
                     control_reg_r[HPS_CTRL_OVD_A]};

  for (genvar s = 0; s < HPS_SLOTS; s++) begin : g_slot
    assign slotPin[s] = pinSync[s*HPS_SLOT_W +: HPS_SLOT_W];

    hps_slot u_slot (
      .clk_sys       (clk_sys),
      .sys_rst       (sys_rst),
      .ce            (ce),
      .mainEn        (slotPin[s][0]),
      .aux_enable         (slotPin[s][1]),
      .overrideN     (slotPin[s][2]),
      .overrideDis   (ovDis[s]),
      .mainOc        (slotPin[s][3]),
      .mainUv        (slotPin[s][4]),
      .mainOt        (slotPin[s][5]),
      .auxOc         (slotPin[s][6]),
      .auxOt         (slotPin[s][7]),
      .auxUvlo       (slotPin[s][8]),
      .mainPwrOk     (slotPin[s][9]),
      .auxPwrOk      (slotPin[s][10]),
      .mainOut_r     (mainOut[s]),
      .auxOut_r      (auxOut[s]),
      .faultN_r      (faultN[s]),
      .powerGoodN_r  (pgN[s]),
      .mainOn_r      (mainOn[s]),
      .auxOn_r       (auxOn[s]),
      .mainFault_r   (mainFault[s]),
      .auxFault_r    (auxFault[s]),
      .forceOn_r     (forceOn[s]),
      .mainFaultEv_r (mainEv[s]),
      .auxFaultEv_r  (auxEv[s])
    );

    assign slotStat[s] = {
      (slotPin[s][6] | slotPin[s][7]),
      (slotPin[s][3] | slotPin[s][4] | slotPin[s][5]),
      ~pgN[s], forceOn[s], auxOut[s], mainOn[s],
      auxFault[s], mainFault[s]
    };

    assign irqSet[2*s]   = mainEv[s];
    assign irqSet[2*s+1] = auxEv[s];
  end

  assign slot_a_fault_n      = faultN[0];
  assign slot_b_fault_n      = faultN[1];
  assign slot_a_power_good_n = pgN[0];
  assign slot_b_power_good_n = pgN[1];
  assign slot_a_main_output  = mainOut[0];
  assign slot_b_main_output  = mainOut[1];
  assign slot_a_aux_output   = auxOut[0];
  assign slot_b_aux_output   = auxOut[1];
  assign busBaseAddr         = baseAddr_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      capCnt_r   <= 2'h0;
      captured_r <= 1'b0;
      baseAddr_r <= HPS_ADDR_RST;
    end else if (ce && !captured_r) begin
      if (capCnt_r == HPS_ADDR_CAP_DLY) begin
        captured_r <= 1'b1;
        baseAddr_r <= addrPins;
      end else begin
        capCnt_r <= capCnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control_reg_r <= HPS_CTRL_RST;
    end else if (ce && regWr && regHit(regAddr, HPS_REG_CONTROL)) begin
      control_reg_r <= regWdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_mask_bit_r <= HPS_MASKBIT_RST;
      irqEn_r        <= HPS_IRQEN_RST;
    end else if (ce && regWr) begin
      if (regHit(regAddr, HPS_REG_COMMON)) begin
        irq_mask_bit_r <= regWdata[HPS_CS_MASK];
      end
      if (regHit(regAddr, HPS_REG_IRQMASK)) begin
        irqEn_r <= regWdata[3:0];
      end
    end
  end

  always_comb begin
    irqClr = 4'h0;
    if (regWr) begin
      if (regHit(regAddr, HPS_REG_IRQSTAT)) begin
        irqClr = regWdata[3:0];
      end
      if (regHit(regAddr, HPS_REG_SLOT_A)) begin
        irqClr[0] = regWdata[HPS_SS_MAIN_FLT];
        irqClr[1] = regWdata[HPS_SS_AUX_FLT];
      end
      if (regHit(regAddr, HPS_REG_SLOT_B)) begin
        irqClr[2] = regWdata[HPS_SS_MAIN_FLT];
        irqClr[3] = regWdata[HPS_SS_AUX_FLT];
      end
      if (regHit(regAddr, HPS_REG_COMMON)) begin
        irqClr[1:0] = {2{regWdata[HPS_CS_FLT_A]}};
        irqClr[3:2] = {2{regWdata[HPS_CS_FLT_B]}};
      end
    end
    // Set wins over clear
    irqStat_nxt = (irqStat_r & ~irqClr) | irqSet;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irqStat_r <= 4'h0;
    end else if (ce) begin
      irqStat_r <= irqStat_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_n <= 1'b1;
    end else if (ce) begin
      irq_n <= ~((|(irqStat_r & irqEn_r)) & ~irq_mask_bit_r);
    end
  end

  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      HPS_REG_CONTROL: rdMux = control_reg_r;
      HPS_REG_COMMON: begin
        rdMux[HPS_CS_FLT_A] = |irqStat_r[1:0];
        rdMux[HPS_CS_FLT_B] = |irqStat_r[3:2];
        rdMux[HPS_CS_MASK]  = irq_mask_bit_r;
        rdMux[HPS_CS_GPA]   = gpA;
        rdMux[HPS_CS_GPB]   = gpB;
      end
      HPS_REG_SLOT_A:  rdMux = slotStat[0];
      HPS_REG_SLOT_B:  rdMux = slotStat[1];
      HPS_REG_IRQSTAT: rdMux = {4'h0, irqStat_r};
      HPS_REG_IRQMASK: rdMux = {4'h0, irqEn_r};
      HPS_REG_ADDR:    rdMux = {5'h00, baseAddr_r};
      default:         rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (ce) begin
      regRdata <= regRd ? rdMux : 8'h00;
    end
  end

endmodule // hps_top
`default_nettype wire

// ==== tb/hps_host_model.sv ====
// Host and load model of one slot: enable pins and power-ok feedback.
// Assumes the bench sets the requested enable levels; clk_sys domain.
`timescale 1ns/10ps
`default_nettype none
module hps_host_model #(
  parameter int unsigned DLY = 1
) (
  input  wire logic clk_sys,
  input  wire logic mainReq,
  input  wire logic auxReq,
  input  wire logic mainOut,
  input  wire logic auxOut,
  output var  logic mainEnable,
  output var  logic auxEnable,
  output var  logic mainPwrOk,
  output var  logic auxPwrOk
);
  int unsigned mainCnt;
  int unsigned auxCnt;

  initial begin
    {mainEnable, auxEnable, mainPwrOk, auxPwrOk} = 4'h0;
    mainCnt = 0;
    auxCnt = 0;
  end

  always @(posedge clk_sys) begin
    mainEnable <= mainReq;
    auxEnable <= auxReq;
  end

  always @(posedge clk_sys) begin
    mainCnt <= mainOut ? mainCnt + 1 : 0;
    auxCnt <= auxOut ? auxCnt + 1 : 0;
    mainPwrOk <= mainOut && (mainCnt >= DLY);
    auxPwrOk <= auxOut && (auxCnt >= DLY);
  end
endmodule // hps_host_model
`default_nettype wire

// ==== tb/hps_top_asserts.sv ====
// Port checks on the slot fault and interrupt block.
// Assumes ce held high; bound into hps_top.
`timescale 1ns/10ps
`default_nettype none
module hps_top_chk
  import hps_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic [HPS_AW-1:0] regAddr,
  input wire logic [HPS_DW-1:0] regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [HPS_DW-1:0] regRdata,
  input wire logic              slot_a_main_enable,
  input wire logic              slot_a_aux_enable,
  input wire logic              slot_a_override_n,
  input wire logic              slot_a_aux_undervoltage_lockout,
  input wire logic              slot_a_fault_n,
  input wire logic              slot_b_fault_n,
  input wire logic              slot_a_main_output,
  input wire logic              slot_a_aux_output,
  input wire logic              irq_n,
  input wire logic [2:0]        busBaseAddr
);
  logic [2:0] addrCnt_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addrCnt_r <= 3'h0;
    end else if (addrCnt_r != 3'h7) begin
      addrCnt_r <= addrCnt_r + 3'h1;
    end
  end

  chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
  chk_aux_level: assert property (
    (!slot_a_aux_enable && slot_a_override_n)[*8] |=> !slot_a_aux_output)
    else $error("aux output on with enable low");
  chk_aux_lockout: assert property (
    slot_a_aux_undervoltage_lockout[*8] |=> !slot_a_aux_output)
    else $error("aux output on under lockout");
  chk_ovr_fault: assert property (
    (!slot_a_override_n)[*6] ##0 slot_a_main_output |-> slot_a_fault_n)
    else $error("fault pin low while forced on");
  chk_fault_hold: assert property (!slot_a_fault_n &&
    slot_a_main_enable && slot_a_aux_enable && slot_a_override_n
    |=> !slot_a_fault_n) else $error("fault released early");
  chk_fault_clear: assert property (
    (!slot_a_main_enable && !slot_a_aux_enable)[*6] |=> slot_a_fault_n)
    else $error("fault kept with enables low");
  chk_irq_echo: assert property (regWr && regAddr == HPS_REG_IRQSTAT &&
    regWdata[3:0] == 4'hF ##1 (slot_a_fault_n && slot_b_fault_n)[*3]
    |-> irq_n) else $error("interrupt not cleared");
  chk_addr_hold: assert property (addrCnt_r == 3'h7
    |-> $stable(busBaseAddr)) else $error("base address moved");

  cover property ($fell(irq_n));
  cover property ($fell(slot_a_fault_n));
  cover property (!slot_a_override_n && slot_a_main_output);
endmodule // hps_top_chk

bind hps_top hps_top_chk u_hps_top_chk (
  .clk_sys, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .slot_a_main_enable, .slot_a_aux_enable, .slot_a_override_n,
  .slot_a_aux_undervoltage_lockout, .slot_a_fault_n, .slot_b_fault_n,
  .slot_a_main_output, .slot_a_aux_output, .irq_n, .busBaseAddr
);
`default_nettype wire

// ==== tb/tb_hps_top.sv ====
// Self-checking bench for the dual-slot fault and interrupt logic.
// Assumes host models drive enables and power-ok; ce held high.
`timescale 1ns/10ps
`default_nettype none
module tb_hps_top;
  import hps_pkg::*;
  logic clk_sys, sys_rst, ce, regWr, regRd, rdPend, irq_n;
  logic slot_a_main_enable, slot_a_aux_enable, slot_a_override_n;
  logic slot_b_main_enable, slot_b_aux_enable, slot_b_override_n;
  logic slot_a_main_oc, slot_a_main_uv, slot_a_main_ot, slot_a_aux_oc;
  logic slot_b_main_oc, slot_b_main_uv, slot_b_main_ot, slot_b_aux_oc;
  logic slot_a_aux_ot, slot_a_aux_undervoltage_lockout, slot_b_aux_ot, slot_b_aux_undervoltage_lockout;
  logic slot_a_main_pwr_ok, slot_a_aux_pwr_ok, slot_b_main_pwr_ok;
  logic slot_b_aux_pwr_ok, gp_input_a, gp_input_b, addr_sel_0;
  logic addr_sel_2, addr_sel_1, slot_a_fault_n, slot_b_fault_n;
  logic slot_a_power_good_n, slot_b_power_good_n, slot_a_main_output;
  logic slot_b_main_output, slot_a_aux_output, slot_b_aux_output;
  logic aMainReq, aAuxReq, bMainReq, bAuxReq;
  logic [2:0] regAddr, busBaseAddr;
  logic [7:0] regWdata, regRdata;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  int   fails, checks;

  hps_top u_hps_top (.*);
  hps_host_model #(.DLY(1)) u_hps_host_model_a (.clk_sys,
    .mainReq(aMainReq), .auxReq(aAuxReq), .mainOut(slot_a_main_output),
    .auxOut(slot_a_aux_output), .mainEnable(slot_a_main_enable),
    .auxEnable(slot_a_aux_enable), .mainPwrOk(slot_a_main_pwr_ok),
    .auxPwrOk(slot_a_aux_pwr_ok));
  hps_host_model #(.DLY(5)) u_hps_host_model_b (.clk_sys,
    .mainReq(bMainReq), .auxReq(bAuxReq), .mainOut(slot_b_main_output),
    .auxOut(slot_b_aux_output), .mainEnable(slot_b_main_enable),
    .auxEnable(slot_b_aux_enable), .mainPwrOk(slot_b_main_pwr_ok),
    .auxPwrOk(slot_b_aux_pwr_ok));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, e, input string n);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic waitv(ref logic s, input logic v, input string n);
    int i;
    for (i = 0; i < 60 && s !== v; i++) @(posedge clk_sys);
    chk(8'(s), 8'(v), n);
    if (s !== v) end_sim();
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, m);
    expQ.push_back(e);
    mskQ.push_back(m);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask

  always @(posedge clk_sys) begin
    rdPend <= regRd;
    if (rdPend) chk(regRdata & mskQ.pop_front(), expQ.pop_front(), "rd");
  end

  initial begin
    {sys_rst, ce, slot_a_override_n, slot_b_override_n} = 4'hF;
    {regWr, regRd, regAddr, regWdata} = '0;
    {aMainReq, aAuxReq, bMainReq, bAuxReq, gp_input_a, gp_input_b} = '0;
    {addr_sel_2, addr_sel_1, addr_sel_0} = 3'h5;
    {slot_a_main_oc, slot_a_main_uv, slot_a_main_ot, slot_a_aux_oc,
     slot_a_aux_ot, slot_a_aux_undervoltage_lockout, slot_b_main_oc, slot_b_main_uv,
     slot_b_main_ot, slot_b_aux_oc, slot_b_aux_ot, slot_b_aux_undervoltage_lockout} = '0;
    {fails, checks} = '0;
    void'($urandom(41637));
    cyc(16);
    sys_rst <= 1'b0;
    cyc(8);
    chk(8'(busBaseAddr), 8'h05, "baseAddr");
    rd(HPS_REG_ADDR, 8'h05, 8'h07);
    rd(3'h7, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {gp_input_b, gp_input_a} <= 2'($urandom);
      cyc(4);
      rd(HPS_REG_COMMON, {2'h0, gp_input_b, gp_input_a, 4'h0}, 8'hFF);
    end
    aMainReq <= 1'b1;
    aAuxReq <= 1'b1;
    waitv(slot_a_main_output, 1'b1, "mainOutA");
    waitv(slot_a_aux_output, 1'b1, "auxOutA");
    waitv(slot_a_power_good_n, 1'b0, "pgA");
    slot_a_main_oc <= 1'b1;
    waitv(slot_a_fault_n, 1'b0, "slot_a_fault_n");
    waitv(irq_n, 1'b0, "irq");
    slot_a_main_oc <= 1'b0;
    slot_a_aux_oc <= 1'b1;
    waitv(slot_a_aux_output, 1'b0, "auxOutA");
    slot_a_aux_oc <= 1'b0;
    rd(HPS_REG_SLOT_A, 8'h03, 8'h03);
    aMainReq <= 1'b0;
    cyc(10);
    chk(8'(slot_a_fault_n), 8'h00, "slot_a_fault_n");
    aAuxReq <= 1'b0;
    waitv(slot_a_fault_n, 1'b1, "slot_a_fault_n");
    wr(HPS_REG_IRQSTAT, 8'h0F);
    waitv(irq_n, 1'b1, "irq");
    wr(HPS_REG_COMMON, 8'h08);
    bMainReq <= 1'b1;
    bAuxReq <= 1'b1;
    waitv(slot_b_power_good_n, 1'b0, "pgB");
    chk(8'(slot_b_aux_output), 8'h01, "auxOutB");
    slot_b_main_uv <= 1'b1;
    waitv(slot_b_fault_n, 1'b0, "slot_b_fault_n");
    slot_b_main_uv <= 1'b0;
    cyc(4);
    chk(8'(irq_n), 8'h01, "irq");
    bMainReq <= 1'b0;
    waitv(slot_b_fault_n, 1'b1, "slot_b_fault_n");
    wr(HPS_REG_COMMON, 8'h00);
    waitv(irq_n, 1'b0, "irq");
    wr(HPS_REG_SLOT_B, 8'h01);
    waitv(irq_n, 1'b1, "irq");
    bAuxReq <= 1'b0;
    aMainReq <= 1'b1;
    aAuxReq <= 1'b1;
    waitv(slot_a_power_good_n, 1'b0, "pgA");
    slot_a_aux_oc <= 1'b1;
    waitv(slot_a_fault_n, 1'b0, "slot_a_fault_n");
    slot_a_aux_oc <= 1'b0;
    slot_a_override_n <= 1'b0;
    slot_a_main_oc <= 1'b1;
    waitv(slot_a_main_output, 1'b1, "mainOutA");
    waitv(slot_a_aux_output, 1'b1, "auxOutA");
    cyc(6);
    chk(8'(slot_a_fault_n), 8'h01, "slot_a_fault_n");
    rd(HPS_REG_SLOT_A, 8'h52, 8'hD3);
    aAuxReq <= 1'b0;
    cyc(6);
    aAuxReq <= 1'b1;
    cyc(12);
    chk(8'(slot_a_power_good_n), 8'h01, "pgA");
    aMainReq <= 1'b0;
    aAuxReq <= 1'b0;
    slot_a_main_oc <= 1'b0;
    slot_a_aux_undervoltage_lockout <= 1'b1;
    waitv(slot_a_aux_output, 1'b0, "auxOutA");
    chk(8'(slot_a_main_output), 8'h01, "mainOutA");
    wr(HPS_REG_CONTROL, 8'h0C);
    waitv(slot_a_main_output, 1'b0, "mainOutA");
    slot_b_override_n <= 1'b0;
    cyc(8);
    chk(8'(slot_b_main_output), 8'h00, "mainOutB");
    rd(HPS_REG_CONTROL, 8'h0C, 8'hFF);
    cyc(3);
    end_sim();
  end
endmodule // tb_hps_top
`default_nettype wire
